// >>> logic/ssr_pkg.sv
// constants for the synthesizer serial register map
// How it works
// (R1) buffered fields go active on register 0 write
// (R2) divider select held only when buffer bit set
// (R3) lock pin follows two-bit lock pin setting
// (R4) register 0 holds whole and numerator values
// (R5) register 5 code 101, lock setting bits 23:22
// (R6) shift data in msb first on clock rise
// (R7) latch strobe rise copies word to selected register
// (R8) codes 110 and 111 change nothing
`default_nettype none
package ssr_pkg;
  localparam int WORD_W = 32;
  localparam int REG_COUNT = 6;
  localparam logic [2:0] SEL_LAST = 3'h5;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // register 0 fields
  localparam int WHOLE_MSB = 30;
  localparam int WHOLE_LSB = 15;
  localparam int NUMER_MSB = 14;
  localparam int NUMER_LSB = 3;
  // register 1 fields
  localparam int PHASE_MSB = 26;
  localparam int PHASE_LSB = 15;
  localparam int DENOM_MSB = 14;
  localparam int DENOM_LSB = 3;
  // register 2 fields
  localparam int DOUBLER_BIT = 25;
  localparam int HALVER_BIT = 24;
  localparam int REFCNT_MSB = 23;
  localparam int REFCNT_LSB = 14;
  localparam int COND_BUF_BIT = 13;
  localparam int PUMP_MSB = 12;
  localparam int PUMP_LSB = 9;
  // register 4 fields
  localparam int DIVSEL_MSB = 22;
  localparam int DIVSEL_LSB = 20;
  // register 5 fields
  localparam int LOCKSET_MSB = 23;
  localparam int LOCKSET_LSB = 22;
  localparam logic [1:0] LOCK_LOW0 = 2'h0;
  localparam logic [1:0] LOCK_DETECT = 2'h1;
  localparam logic [1:0] LOCK_LOW2 = 2'h2;
  localparam logic [1:0] LOCK_HIGH = 2'h3;
endpackage : ssr_pkg
`default_nettype wire

// >>> logic/ssr_register_map.sv
// serial programming port and register bank of the synthesizer
`timescale 1ns/100ps
`default_nettype none
module ssr_register_map (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  input wire logic lock_detect_in,
  output logic [15:0] whole_value_out,
  output logic [11:0] numerator_value_out,
  output logic [11:0] phase_value_out,
  output logic [11:0] denominator_value_out,
  output logic reference_doubler_out,
  output logic reference_halver_out,
  output logic [9:0] reference_count_out,
  output logic [3:0] pump_current_out,
  output logic [2:0] divider_select_out,
  output logic [31:0] prescaler_phase_modulus_out,
  output logic [31:0] reference_and_loop_control_out,
  output logic [31:0] clock_divider_control_out,
  output logic [31:0] output_stage_control_out,
  output logic [31:0] lock_pin_control_out,
  output logic lock_pin_out
);
  // two-stage synchronisers; stage one is read only by stage two
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sck_prev;
  logic le_prev;
  logic [31:0] shift_word;
  logic [31:0] bank [ssr_pkg::REG_COUNT];
  logic [31:0] act_r1;
  logic [31:0] act_r2;
  logic [2:0] act_divsel;
  logic [2:0] next_sync_a;
  logic [2:0] next_sync_b;
  logic next_sck_prev;
  logic next_le_prev;
  logic [31:0] next_shift_word;
  logic [31:0] next_bank [ssr_pkg::REG_COUNT];
  logic [31:0] next_act_r1;
  logic [31:0] next_act_r2;
  logic [2:0] next_act_divsel;
  logic sck_rise;
  logic le_rise;
  logic latch_ok;
  logic [2:0] sel;
  logic cond_buf;

  // output divider select field of a stored register 4 word
  function automatic logic [2:0] divsel_of(input logic [31:0] word);
    divsel_of = word[ssr_pkg::DIVSEL_MSB:ssr_pkg::DIVSEL_LSB];
  endfunction : divsel_of

  // true when an accepted strobe targets register idx
  function automatic logic write_hits(input logic ok, input logic [2:0] code,
    input logic [2:0] idx);
    write_hits = ok && (code == idx);
  endfunction : write_hits

  // next values of the synchronisers and the edge history
  always_comb
  begin
    next_sync_a = {latch_strobe_in, serial_data_in, serial_clock_in};
    next_sync_b = sync_a;
    next_sck_prev = sync_b[0];
    next_le_prev = sync_b[2];
  end

  // synchronise serial pins into the system clock
  // edge history resets low, the idle level of both pins, so no false edge
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sck_prev <= 1'b0;
      le_prev <= 1'b0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sck_prev <= next_sck_prev;
      le_prev <= next_le_prev;
    end
  end

  assign sck_rise = sync_b[0] & ~sck_prev;
  assign le_rise = sync_b[2] & ~le_prev;
  assign sel = shift_word[2:0];
  // a strobe with code 110 or 111 is dropped here [R8]
  assign latch_ok = le_rise && (sel <= ssr_pkg::SEL_LAST);
  // the buffer bit is taken from the stored register 2 word
  assign cond_buf = bank[2][ssr_pkg::COND_BUF_BIT];

  // one write path per stored register; a refused code hits none [R7]
  for (genvar g = 0; g < ssr_pkg::REG_COUNT; g++)
  begin : g_bank
    always_comb
    begin
      next_bank[g] = bank[g];
      if (write_hits(latch_ok, sel, 3'(g)))
      begin
        next_bank[g] = shift_word; // [R7]
      end
    end

    // stored words; no documented reset value, zero chosen
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
      if (!resetn_in)
      begin
        bank[g] <= ssr_pkg::REG_RESET;
      end
      else
      begin
        bank[g] <= next_bank[g];
      end
    end
  end

  // shift and double-buffer transfer
  always_comb
  begin
    next_shift_word = shift_word;
    next_act_r1 = act_r1;
    next_act_r2 = act_r2;
    next_act_divsel = act_divsel;
    if (sck_rise)
    begin
      next_shift_word = {shift_word[30:0], sync_b[1]}; // msb first [R6]
    end
    // a strobe rise and a clock rise together: strobe sees the old word
    // unbuffered divider select applies on its own load [R2]
    if (write_hits(latch_ok, sel, 3'h4) && !cond_buf)
    begin
      next_act_divsel = divsel_of(shift_word); // [R2]
    end
    // register 0 write pushes all buffered fields live [R1]
    // the stored words at that moment are taken, not the incoming one
    if (write_hits(latch_ok, sel, 3'h0))
    begin
      next_act_r1 = bank[1];
      next_act_r2 = bank[2];
      next_act_divsel = divsel_of(bank[4]); // [R2]
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shift_word <= ssr_pkg::REG_RESET;
      act_r1 <= ssr_pkg::REG_RESET;
      act_r2 <= ssr_pkg::REG_RESET;
      act_divsel <= 3'h0;
    end
    else
    begin
      shift_word <= next_shift_word;
      act_r1 <= next_act_r1;
      act_r2 <= next_act_r2;
      act_divsel <= next_act_divsel;
    end
  end

  // register 0 fields apply directly [R4]
  assign whole_value_out = bank[0][ssr_pkg::WHOLE_MSB:ssr_pkg::WHOLE_LSB];
  assign numerator_value_out = bank[0][ssr_pkg::NUMER_MSB:ssr_pkg::NUMER_LSB];
  // buffered copies feed the active fields [R1]
  assign phase_value_out = act_r1[ssr_pkg::PHASE_MSB:ssr_pkg::PHASE_LSB];
  assign denominator_value_out = act_r1[ssr_pkg::DENOM_MSB:ssr_pkg::DENOM_LSB];
  assign reference_doubler_out = act_r2[ssr_pkg::DOUBLER_BIT];
  assign reference_halver_out = act_r2[ssr_pkg::HALVER_BIT];
  assign reference_count_out = act_r2[ssr_pkg::REFCNT_MSB:ssr_pkg::REFCNT_LSB];
  assign pump_current_out = act_r2[ssr_pkg::PUMP_MSB:ssr_pkg::PUMP_LSB];
  assign divider_select_out = act_divsel;
  assign prescaler_phase_modulus_out = bank[1];
  assign reference_and_loop_control_out = bank[2];
  assign clock_divider_control_out = bank[3];
  assign output_stage_control_out = bank[4];
  assign lock_pin_control_out = bank[5];

  // lock pin mux; lock detect comes from on-chip logic, same clock
  always_comb
  begin
    unique case (bank[5][ssr_pkg::LOCKSET_MSB:ssr_pkg::LOCKSET_LSB]) // [R5]
      ssr_pkg::LOCK_LOW0: lock_pin_out = 1'b0; // [R3]
      ssr_pkg::LOCK_DETECT: lock_pin_out = lock_detect_in; // [R3]
      ssr_pkg::LOCK_LOW2: lock_pin_out = 1'b0; // [R3]
      ssr_pkg::LOCK_HIGH: lock_pin_out = 1'b1; // [R3]
    endcase
  end
endmodule : ssr_register_map
`default_nettype wire

// >>> sim/ssr_checker.sv
// port assertions for the serial register map
`timescale 1ns/100ps
`default_nettype none
module ssr_checker (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic latch_strobe_in,
  input wire logic lock_detect_in,
  input wire logic lock_pin_out,
  input wire logic [2:0] divider_select_out,
  input wire logic [31:0] reference_and_loop_control_out,
  input wire logic [31:0] output_stage_control_out,
  input wire logic [31:0] lock_pin_control_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // field views of the stored words
  wire logic [1:0] mode = lock_pin_control_out[23:22];
  wire logic hold = reference_and_loop_control_out[13];
  wire logic [2:0] sel = output_stage_control_out[22:20];
  // lock pin, divider select timing, and strobe as the only cause of change
  AST_LOCK_LOW: assert property (!mode[0] |-> !lock_pin_out) else $error("pin not low");
  AST_LOCK_DET: assert property (mode == 2'h1 |-> lock_pin_out == lock_detect_in)
    else $error("pin not detect");
  AST_LOCK_HIGH: assert property (mode == 2'h3 |-> lock_pin_out) else $error("pin not high");
  AST_DIV_NOW: assert property ($changed(sel) && !hold |-> ##[0:1] divider_select_out == sel)
    else $error("divider late");
  AST_DIV_HELD: assert property ($changed(sel) && hold |-> $stable(divider_select_out) [*3])
    else $error("divider early");
  AST_DIV_ON_R0: assert property ($changed(divider_select_out) && hold |-> divider_select_out == sel)
    else $error("divider wrong");
  AST_DIV_STROBE: assert property ($changed(divider_select_out) |-> $past(latch_strobe_in, 2))
    else $error("divider moved alone");
  AST_LOCK_STROBE: assert property ($changed(lock_pin_control_out) |-> $past(latch_strobe_in, 2))
    else $error("word moved alone");
endmodule : ssr_checker
`default_nettype wire

// >>> sim/ssr_host.sv
// host model driving the three-wire programming port
`timescale 1ns/100ps
`default_nettype none
module ssr_host (
  input wire logic mclk_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic strobe_out
);
  initial {sclk_out, sdata_out, strobe_out} = 3'h0;
  // 80 ns low with the new bit, 80 ns high; clock rests low outside frames
  task automatic send(input logic [31:0] w);
    for (int i = 63; i >= 0; i--)
      repeat (8) @(negedge mclk_in) {sdata_out, sclk_out} = {w[i / 2], ~i[0]};
    // released data shows the inverse so a stale bit cannot pass
    @(negedge mclk_in) {sdata_out, sclk_out} = {~w[0], 1'h0};
    repeat (8) @(negedge mclk_in) strobe_out = 1'h1;
    repeat (8) @(negedge mclk_in) strobe_out = 1'h0;
  endtask : send
endmodule : ssr_host
`default_nettype wire

// >>> sim/ssr_register_map_test.sv
// bench for the serial register map
`timescale 1ns/100ps
`default_nettype none
module ssr_register_map_test;
  logic mclk_in = 1'h0, resetn_in = 1'h0, lock_detect_in = 1'h0, sck, sdi, stb;
  int num_errors = 0, n_tests = 0;
  always #5 mclk_in = ~mclk_in;
  ssr_host host (.mclk_in, .sclk_out(sck), .sdata_out(sdi), .strobe_out(stb));
  logic [15:0] whole;
  logic [11:0] numer, phase, denom;
  logic doubler, halver, lock_pin;
  logic [9:0] ref_count;
  logic [3:0] pump;
  logic [2:0] divsel;
  logic [31:0] word1, word2, word3, word4, word5;
  ssr_register_map DUT (.mclk_in, .resetn_in, .serial_clock_in(sck), .serial_data_in(sdi),
    .latch_strobe_in(stb), .lock_detect_in, .whole_value_out(whole),
    .numerator_value_out(numer), .phase_value_out(phase), .denominator_value_out(denom),
    .reference_doubler_out(doubler), .reference_halver_out(halver),
    .reference_count_out(ref_count), .pump_current_out(pump), .divider_select_out(divsel),
    .prescaler_phase_modulus_out(word1), .reference_and_loop_control_out(word2),
    .clock_divider_control_out(word3), .output_stage_control_out(word4),
    .lock_pin_control_out(word5), .lock_pin_out(lock_pin));
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    n_tests++;
    num_errors += int'(a !== e);
    if (a !== e) $display("unexpected at %0t: %h not %h", $time, a, e);
  endtask : check
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // buffered fields wait for a register 0 write
  task automatic t_buffer;
    host.send({5'h0, 12'h123, 12'h456, 3'h1});
    check(32'h0, 32'(denom));
    check(32'h0091_A2B1, word1);
    host.send({1'h1, 16'hABCD, 12'h5A3, 3'h0});
    check(32'hABCD_05A3, {whole, 4'h0, numer});
    check(32'h0123_0456, {4'h0, phase, 4'h0, denom});
    host.send(32'h0050_0004);
    check(32'h5, 32'(divsel));
    host.send({6'h0, 2'h2, 10'h2A5, 1'h1, 4'h9, 9'h2});
    check(32'h02A9_7202, word2);
    host.send(32'h0030_0004);
    check(32'h5, 32'(divsel));
    check(32'h0030_0004, word4);
    host.send(32'h0);
    check({13'h0, 3'h3, 2'h2, 10'h2A5, 4'h9}, {13'h0, divsel,
      doubler, halver, ref_count, pump});
  endtask : t_buffer
  // every lock pin setting with detect low and high, then refused codes
  task automatic t_lock;
    for (int m = 0; m < 8; m++)
    begin
      host.send(32'h0018_0005 | (32'(m % 4) << 22));
      lock_detect_in = m[2];
      @(negedge mclk_in) check(32'(m % 4 == 3 || m == 5), 32'(lock_pin));
    end
    host.send(32'h1234_5673);
    host.send(32'hFFFF_FFFE);
    host.send(32'hFFFF_FFFF);
    check(32'h1234_5673, word3);
    check(32'h00D8_0005, word5);
    check(32'h0030_0004, word4);
  endtask : t_lock
  initial
  begin
    repeat (10) @(negedge mclk_in);
    resetn_in = 1'h1;
    repeat (4) @(negedge mclk_in);
    t_buffer();
    t_lock();
    print_verdict();
  end
  // hang guard, about four times the expected run
  initial
  begin
    repeat (40000) @(posedge mclk_in);
    num_errors++;
    print_verdict();
  end
endmodule : ssr_register_map_test
bind ssr_register_map ssr_checker chk (.*);
`default_nettype wire
